// >>> link_deser.sv
// link sampler: rebuilds 48-bit words from eight serial lanes
`timescale 1ns/1ps
module link_deser import lwc_pkg::*; (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             resetn,
  // link pins
  input wire logic             link_clk,
  input wire logic             link_frame,
  input wire logic [LANES-1:0] link_data,
  // words out
  word_if.src                  wout
);
  typedef struct packed {
    logic [LANES+1:0]  meta;
    logic [LANES+1:0]  sync;
    logic              prev_clk;
    logic [2:0]        beat;
    logic [WORD_W-1:0] shift;
    logic              vld;
    logic [WORD_W-1:0] word;
  } deser_t;

  deser_t q, n;
  logic [WORD_W-1:0] sh_nxt;

  always_comb begin
    n = q;
    n.meta = {link_clk, link_frame, link_data};
    n.sync = q.meta;
    n.prev_clk = q.sync[LANES+1];
    n.vld = 1'b0;
    sh_nxt = {q.shift[WORD_W-LANES-1:0], q.sync[LANES-1:0]};
    // six beats of eight lanes, first beat marked by the frame pin
    if (q.sync[LANES+1] && !q.prev_clk) begin
      if (q.sync[LANES]) begin
        n.shift = sh_nxt; // RULE_01
        n.beat = 3'h1;
      end else if (q.beat != 3'h0) begin
        n.shift = sh_nxt;
        if (q.beat == BEAT_LAST) begin
          n.vld = 1'b1; // RULE_02
          n.word = sh_nxt;
          n.beat = 3'h0;
        end else begin
          n.beat = q.beat + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign wout.vld = q.vld;
  assign wout.data = q.word;

  property p_word_pulse;
    @(posedge ref_clk) disable iff (!resetn) wout.vld |=> !wout.vld;
  endproperty
  a_word_pulse: assert property (p_word_pulse) else $error("word strobe longer than one cycle"); // RULE_01
endmodule

// >>> link_word_checker.sv
// link word checker: classifies, checks, stamps and stores link words
//
// Behaviour
// (RULE_01) 48-bit words come over eight serial lanes and are rebuilt in parallel.
// (RULE_02) word rate follows the source: 80 MHz controllers, 100 MHz receiver unit.
// (RULE_03) every non-idle word is checked, stamped and pushed into the receive fifo.
// (RULE_04) parity error flag is sticky until the fifo is cleared.
// (RULE_05) three receiving modes, one per source format, selected by software.
// (RULE_06) entry is 64 bits: word low, 16-bit interval field high.
// (RULE_07) receiver-unit mode counts from a control word to next control or data.
// (RULE_08) error and fifo status are readable over the register port.
// (RULE_09) frequency mode: A then B adjacent; A stamped with A-to-A cycles. The code counts taken words, not ref_clk cycles.
// (RULE_10) interval low half on first entry, high half on the following one.
// (RULE_11) frequency mode: bit 46 selects word A (0) or word B (1).
// (RULE_12) frequency mode: bit 47 carries the transmitter reference clock level.
// (RULE_13) frequency mode: even parity over bits 1 to 46 in bit 48.
// (RULE_14) gradient mode: data words then one commit word, gaps allowed.
// (RULE_15) gradient mode: stamp counts cycles since the previous commit word. The code counts taken words, not ref_clk cycles.
// (RULE_16) gradient type field: 00 illegal, 01 data, 10 commit, 11 idle.
// (RULE_17) gradient mode: even parity over bits 1 to 47 in bit 48.
// (RULE_18) far end activates gradient data when a commit word arrives.
// (RULE_19) receiver-unit type field: 00 illegal, 01 data, 10 control, 11 idle.
// (RULE_20) receiver-unit mode: even parity over bits 1 to 47.
// (RULE_21) idle words are not stored; counter restarts when a measured word is stamped.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module link_word_checker import lwc_pkg::*; (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // link pins
  input  wire logic              link_clk,
  input  wire logic              link_frame,
  input  wire logic [LANES-1:0]  link_data,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  // status
  output logic                   parity_error,
  output logic                   fifo_not_empty
);
  ////////////////////////////////////////////////////////////////////////////
  // submodules

  word_if win ();
  fifo_if fio ();

  link_deser u_deser (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .link_clk   (link_clk),
    .link_frame (link_frame),
    .link_data  (link_data),
    .wout       (win.src)
  );

  rx_fifo u_fifo (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .fio     (fio.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rx_mode_t          mode;
    logic              en;
    logic              parity_err;
    logic              type_err;
    logic              seq_err;
    logic              ovf;
    logic [CNT_W-1:0]  cnt;
    logic              hi_pend;
    logic [STAMP_W-1:0] hi_val;
    logic              after_a;
    logic [DATA_W-1:0] rd_data;
    logic              nempty;
  } chk_t;

  chk_t q, n;

  ////////////////////////////////////////////////////////////////////////////
  // word classification

  logic [WORD_W-1:0] w;
  word_kind_t        kind;
  logic              is_freq;
  logic              take;
  logic              is_idle;
  logic              par_bad;
  logic              illegal;
  logic              measured;
  logic              store;
  logic              clr;
  logic              wsel;
  logic [CNT_W-1:0]  stamp;
  logic [STAMP_W-1:0] upper;

  assign w = win.data;
  assign kind = word_kind_t'(w[1:0]); // RULE_16 RULE_19
  assign is_freq = (q.mode == frequency_source_mode);
  assign wsel = w[WSEL_POS]; // RULE_11
  assign take = win.vld && q.en; // RULE_14
  assign is_idle = !is_freq && (kind == kind_idle);
  assign illegal = take && !is_freq && (kind == kind_illegal);

  // even parity: the parity bit plus its covered bits xor to zero
  always_comb begin
    if (is_freq) begin
      par_bad = take && (^{w[EVEN_PAR_POS], w[WSEL_POS:0]}); // RULE_13
    end else begin
      par_bad = take && !is_idle && (^w); // RULE_17 RULE_20
    end
  end

  // the measured word restarts the interval count
  always_comb begin
    unique case (q.mode)
      frequency_source_mode: measured = !wsel; // RULE_09
      gradient_source_mode:  measured = (kind == kind_commit); // RULE_15
      receiver_unit_mode:    measured = (kind == kind_commit); // RULE_07
      default:               measured = 1'b0;
    endcase
  end

  assign store = take && !is_idle; // RULE_21
  // saturate so a very long gap never wraps into a short one
  assign stamp = (&q.cnt) ? q.cnt : q.cnt + 1'b1;
  assign upper = (q.hi_pend && !measured) ? q.hi_val : stamp[STAMP_W-1:0]; // RULE_10
  assign clr = wr_en && (addr == REG_CTRL) && wr_data[CTRL_CLR_BIT];

  assign fio.push = store; // RULE_03
  assign fio.wdata = {upper, w}; // RULE_06
  assign fio.pop = rd_en && (addr == REG_DATA_HI);
  assign fio.clr = clr;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    n.nempty = !fio.empty;
    if (wr_en && (addr == REG_CTRL)) begin
      // code 11 is no mode; the old mode stays
      if (wr_data[CTRL_MODE_LSB+1:CTRL_MODE_LSB] != 2'h3) begin
        n.mode = rx_mode_t'(wr_data[CTRL_MODE_LSB+1:CTRL_MODE_LSB]); // RULE_05
      end
      n.en = wr_data[CTRL_EN_BIT];
    end
    // sticky flags: a set in the clearing cycle wins
    n.parity_err = (q.parity_err && !clr) || par_bad; // RULE_04
    n.type_err = (q.type_err && !clr) || illegal; // RULE_16 RULE_19
    n.ovf = (q.ovf && !clr) || (store && fio.full);
    n.seq_err = q.seq_err && !clr;
    if (take) begin
      n.cnt = measured ? '0 : stamp; // RULE_21
      if (is_freq) begin
        // B must follow A in the very next word slot
        if (q.after_a == !wsel) n.seq_err = 1'b1; // RULE_09
        n.after_a = !wsel;
      end
    end
    if (store) begin
      n.hi_pend = measured; // RULE_10
      n.hi_val = stamp[CNT_W-1:STAMP_W];
    end
    if (clr) begin
      n.hi_pend = 1'b0;
      n.after_a = 1'b0;
    end
    if (rd_en) begin
      unique case (addr)
        REG_CTRL: n.rd_data = {{(DATA_W-3){1'b0}}, q.en, q.mode};
        REG_STATUS: n.rd_data = {{(DATA_W-8){1'b0}}, q.mode, fio.full, fio.empty,
                                 q.ovf, q.seq_err, q.type_err, q.parity_err}; // RULE_08
        REG_LEVEL: n.rd_data = {{(DATA_W-FIFO_AW-1){1'b0}}, fio.level};
        REG_DATA_LO: n.rd_data = fio.empty ? '0 : fio.rdata[DATA_W-1:0];
        REG_DATA_HI: n.rd_data = fio.empty ? '0 : fio.rdata[ENTRY_W-1:DATA_W];
        default: n.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.mode <= MODE_RST;
      q.en <= EN_RST;
    end else begin
      q <= n;
    end
  end

  assign rd_data = q.rd_data;
  assign parity_error = q.parity_err;
  assign fifo_not_empty = q.nempty;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_par_set;
    par_bad |=> q.parity_err;
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity error not flagged"); // RULE_13

  property p_par_hold;
    q.parity_err && !clr |=> q.parity_err;
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity flag dropped"); // RULE_04

  property p_idle_skip;
    take && is_idle |-> !fio.push;
  endproperty
  a_idle_skip: assert property (p_idle_skip) else $error("idle word stored"); // RULE_21

  property p_store;
    take && !is_idle |-> fio.push && (fio.wdata[WORD_W-1:0] == win.data);
  endproperty
  a_store: assert property (p_store) else $error("word not stored intact"); // RULE_03

  property p_restart;
    take && measured |=> q.cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // RULE_21

  property p_split;
    store && measured && !clr |=> q.hi_pend && q.hi_val == $past(stamp[CNT_W-1:STAMP_W]);
  endproperty
  a_split: assert property (p_split) else $error("high half not held"); // RULE_10

  property p_hi_use;
    store && q.hi_pend && !measured |-> fio.wdata[ENTRY_W-1:STAMP_LSB] == q.hi_val;
  endproperty
  a_hi_use: assert property (p_hi_use) else $error("high half not written"); // RULE_10

  property p_freq_stamp;
    store && is_freq && !wsel |-> fio.wdata[ENTRY_W-1:STAMP_LSB] == stamp[STAMP_W-1:0];
  endproperty
  a_freq_stamp: assert property (p_freq_stamp) else $error("word A stamp wrong"); // RULE_09

  property p_type_err;
    illegal |=> q.type_err;
  endproperty
  a_type_err: assert property (p_type_err) else $error("illegal type not flagged"); // RULE_16

  property p_status_read;
    rd_en && addr == REG_STATUS |=> rd_data[0] == $past(q.parity_err);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RULE_08

  property p_type_hold;
    q.type_err && !clr |=> q.type_err;
  endproperty
  a_type_hold: assert property (p_type_hold) else $error("type flag dropped"); // RULE_16

  property p_par_clr;
    clr && !par_bad |=> !q.parity_err;
  endproperty
  a_par_clr: assert property (p_par_clr) else $error("parity flag not cleared"); // RULE_04

  property p_seq_hold;
    q.seq_err && !clr |=> q.seq_err;
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence flag dropped"); // RULE_09

  property p_ovf_set;
    store && fio.full |=> q.ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged"); // RULE_03

  property p_clr_empty;
    clr |=> fio.empty;
  endproperty
  a_clr_empty: assert property (p_clr_empty) else $error("fifo not cleared"); // RULE_04

  property p_push_level;
    fio.push && !fio.full && !fio.pop && !clr |=> fio.level == $past(fio.level) + 1'b1;
  endproperty
  a_push_level: assert property (p_push_level) else $error("push not counted"); // RULE_03

  property p_b_lone;
    take && is_freq && wsel && !q.after_a |=> q.seq_err;
  endproperty
  a_b_lone: assert property (p_b_lone) else $error("lone B not flagged"); // RULE_09

  property p_a_twice;
    take && is_freq && !wsel && q.after_a |=> q.seq_err;
  endproperty
  a_a_twice: assert property (p_a_twice) else $error("A after A not flagged"); // RULE_09

  property p_after_a;
    take && is_freq && !clr |=> q.after_a == !$past(wsel);
  endproperty
  a_after_a: assert property (p_after_a) else $error("word select not tracked"); // RULE_11

  property p_grad_stamp;
    store && q.mode == gradient_source_mode && measured
      |-> fio.wdata[ENTRY_W-1:STAMP_LSB] == stamp[STAMP_W-1:0];
  endproperty
  a_grad_stamp: assert property (p_grad_stamp) else $error("commit stamp wrong"); // RULE_15

  property p_ru_stamp;
    store && q.mode == receiver_unit_mode && measured
      |-> fio.wdata[ENTRY_W-1:STAMP_LSB] == stamp[STAMP_W-1:0];
  endproperty
  a_ru_stamp: assert property (p_ru_stamp) else $error("control stamp wrong"); // RULE_07

  property p_off_drop;
    win.vld && !q.en |-> !fio.push;
  endproperty
  a_off_drop: assert property (p_off_drop) else $error("word stored while off"); // RULE_03

  property p_ill_store;
    illegal |-> fio.push;
  endproperty
  a_ill_store: assert property (p_ill_store) else $error("illegal word not stored"); // RULE_03

  property p_rd_level;
    rd_en && addr == REG_LEVEL |=> rd_data[FIFO_AW:0] == $past(fio.level);
  endproperty
  a_rd_level: assert property (p_rd_level) else $error("level read wrong"); // RULE_08

  property p_rd_ctrl;
    rd_en && addr == REG_CTRL |=> rd_data[CTRL_MODE_LSB+1:CTRL_MODE_LSB] == $past(q.mode);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("mode read wrong"); // RULE_05

  property p_rd_hold;
    !rd_en |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved"); // RULE_08

  property p_nempty_on;
    !fio.empty |=> fifo_not_empty;
  endproperty
  a_nempty_on: assert property (p_nempty_on) else $error("not-empty output low"); // RULE_08

  c_freq_a: cover property (store && is_freq && !wsel);
  c_grad_commit: cover property (store && q.mode == gradient_source_mode && measured);
  c_recv_ctrl: cover property (store && q.mode == receiver_unit_mode && measured);
  c_par_err: cover property (par_bad);
  c_seq_err: cover property (q.seq_err);
endmodule

// >>> link_word_checker_test.sv
// self-checking bench of the link word checker
`timescale 1ns/1ps
module link_word_checker_test import lwc_pkg::*; ;
  logic              ref_clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic              rd_en;
  logic              parity_error;
  logic              fifo_not_empty;
  logic              link_clk;
  logic              link_frame;
  logic [LANES-1:0]  link_data;
  int                failures;
  int                n_checks;
  int                cycles;

  link_word_checker u_link_word_checker (
    .ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .link_frame(link_frame),
    .link_data(link_data), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .parity_error(parity_error), .fifo_not_empty(fifo_not_empty));
  lwc_link_tx u_lwc_link_tx (.link_clk(link_clk), .link_frame(link_frame), .link_data(link_data));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ceiling: about five times 23 words of 150 cycles plus register traffic
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [47:0] fword(input logic s, input logic id, input logic [44:0] d);
    logic [47:0] w;
    w     = {1'b0, s, id, d};
    w[47] = ^w[45:0];
    return w;
  endfunction

  // gradient and receiver-unit words share the layout
  function automatic logic [47:0] gword(input logic [44:0] d, input logic [1:0] k);
    logic [47:0] w;
    w     = {1'b0, d, k};
    w[47] = ^w[46:0];
    return w;
  endfunction

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk32(n, e, v);
  endtask

  // start off the sampling edge so link edges never meet ref_clk edges
  task automatic send(input logic [47:0] w);
    @(posedge ref_clk);
    #1 u_lwc_link_tx.send(w);
  endtask

  task automatic settle;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic chk_entry(input logic [47:0] w, input bit s, input logic [15:0] st);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(REG_DATA_LO, lo);
    rd(REG_DATA_HI, hi);
    chk32("entry_lo", w[31:0], lo);
    chk32("entry_hi", {s ? st : hi[31:16], w[47:32]}, hi);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk("ctrl", REG_CTRL, 32'h0);
    rd_chk("status", REG_STATUS, 32'h10);
    rd_chk("level", REG_LEVEL, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    wr(8'h24, 32'hffff_ffff);
    rd_chk("ctrl", REG_CTRL, 32'h0);
    send(fword(1'b0, 1'b0, 45'h1));
    settle();
    rd_chk("level", REG_LEVEL, 32'h0);
    chk1("fifo_not_empty", 1'b0, fifo_not_empty);
  endtask

  task automatic t_freq;
    logic [47:0] w [4];
    w[0] = fword(1'b1, 1'b0, 45'h0123_4567_89a);
    w[1] = fword(1'b1, 1'b1, 45'h1abc_def0_123);
    w[2] = fword(1'b0, 1'b0, 45'h0f0f_0f0f_0f0);
    w[3] = fword(1'b0, 1'b1, 45'h1555_aaaa_555);
    wr(REG_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) send(w[i]);
    settle();
    rd_chk("level", REG_LEVEL, 32'h4);
    rd_chk("status", REG_STATUS, 32'h0);
    chk1("parity_error", 1'b0, parity_error);
    chk1("fifo_not_empty", 1'b1, fifo_not_empty);
    chk_entry(w[0], 1'b0, 16'h0);
    chk_entry(w[1], 1'b1, 16'h0);
    chk_entry(w[2], 1'b1, 16'h0002);
    chk_entry(w[3], 1'b1, 16'h0000);
    // lone B, then an A with a broken parity bit
    send(w[3]);
    send(w[2] ^ 48'h8000_0000_0000);
    settle();
    rd_chk("status", REG_STATUS, 32'h5);
    send(w[3]);
    settle();
    chk1("parity_error", 1'b1, parity_error);
    wr(REG_CTRL, 32'hc);
    repeat (3) @(posedge ref_clk);
    chk1("parity_error", 1'b0, parity_error);
    chk1("fifo_not_empty", 1'b0, fifo_not_empty);
    rd_chk("status", REG_STATUS, 32'h10);
    rd_chk("ctrl", REG_CTRL, 32'h4);
  endtask

  task automatic t_grad;
    logic [47:0] w [6];
    w[0] = gword(45'h0111_2222_333, 2'b01);
    w[1] = gword(45'h0, 2'b11);
    w[2] = gword(45'h1444_5555_666, 2'b01);
    w[3] = gword(45'h0, 2'b10);
    w[4] = gword(45'h0777_8888_999, 2'b01);
    w[5] = gword(45'h0, 2'b10);
    wr(REG_CTRL, 32'h5);
    rd_chk("status", REG_STATUS, 32'h50);
    send(w[0]);
    send(w[1]);
    send(w[2]);
    repeat (40) @(posedge ref_clk);
    for (int i = 3; i < 6; i++) send(w[i]);
    settle();
    rd_chk("level", REG_LEVEL, 32'h5);
    chk_entry(w[0], 1'b0, 16'h0);
    chk_entry(w[2], 1'b0, 16'h0);
    chk_entry(w[3], 1'b0, 16'h0);
    chk_entry(w[4], 1'b1, 16'h0);
    chk_entry(w[5], 1'b1, 16'h0002);
    send(gword(45'h0, 2'b00));
    send(w[0] ^ 48'h4000_0000_0000);
    settle();
    rd_chk("status", REG_STATUS, 32'h43);
    chk1("parity_error", 1'b1, parity_error);
    wr(REG_CTRL, 32'hd);
    rd_chk("status", REG_STATUS, 32'h50);
  endtask

  task automatic t_ru;
    logic [47:0] w [5];
    w[0] = gword(45'h0abc_0000_123, 2'b10);
    w[1] = gword(45'h0, 2'b11);
    w[2] = gword(45'h0, 2'b11);
    w[3] = gword(45'h1def_0000_456, 2'b10);
    w[4] = gword(45'h0135_7924_680, 2'b01);
    wr(REG_CTRL, 32'h6);
    for (int i = 0; i < 5; i++) send(w[i]);
    settle();
    rd_chk("level", REG_LEVEL, 32'h3);
    chk_entry(w[0], 1'b0, 16'h0);
    chk_entry(w[3], 1'b1, 16'h0003);
    chk_entry(w[4], 1'b1, 16'h0000);
    send(gword(45'h0, 2'b00));
    settle();
    rd_chk("status", REG_STATUS, 32'h82);
    send(w[4] ^ 48'h4000_0000_0000);
    settle();
    rd_chk("status", REG_STATUS, 32'h83);
    wr(REG_CTRL, 32'he);
    rd_chk("status", REG_STATUS, 32'h90);
    wr(REG_CTRL, 32'h7);
    rd_chk("ctrl", REG_CTRL, 32'h6);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    cycles   = 0;
    resetn   = 1'b0;
    addr     = 8'h00;
    wr_data  = 32'h0;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_freq();
    t_grad();
    t_ru();
    finish_test();
  end
endmodule

// >>> lwc_ifs.sv
// carriers between the checker and its deserialiser and fifo
`timescale 1ns/1ps
interface word_if import lwc_pkg::*; ();
  logic              vld;
  logic [WORD_W-1:0] data;
  modport src (output vld, output data);
  modport snk (input vld, input data);
endinterface

interface fifo_if import lwc_pkg::*; ();
  logic               push;
  logic [ENTRY_W-1:0] wdata;
  logic               pop;
  logic               clr;
  logic [ENTRY_W-1:0] rdata;
  logic               full;
  logic               empty;
  logic [FIFO_AW:0]   level;
  modport ctl (output push, wdata, pop, clr, input rdata, full, empty, level);
  modport mem (input push, wdata, pop, clr, output rdata, full, empty, level);
endinterface

// >>> lwc_link_tx.sv
// link transmitter model: six beats of eight lanes per word
`timescale 1ns/1ps
module lwc_link_tx import lwc_pkg::*; (
  // link pins
  output logic             link_clk,
  output logic             link_frame,
  output logic [LANES-1:0] link_data
);
  initial begin
    link_clk   = 1'b0;
    link_frame = 1'b0;
    link_data  = 8'h00;
  end

  // clock stands low between words; released lanes show the inverse
  task automatic send(input logic [WORD_W-1:0] w);
    for (int b = 0; b < 6; b++) begin
      link_frame = (b == 0);
      link_data  = w[47-8*b -: 8];
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
    link_frame = 1'b0;
    link_data  = ~link_data;
  endtask
endmodule

// >>> lwc_pkg.sv
// shared constants and types of the link word checker
package lwc_pkg;
  localparam int LANES      = 8;
  localparam int WORD_W     = 48;
  localparam int ENTRY_W    = 64;
  localparam int STAMP_W    = 16;
  localparam int CNT_W      = 32;
  localparam int FIFO_DEPTH = 8192;
  localparam int FIFO_AW    = 13;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam logic [2:0] BEAT_LAST = 3'h5;

  typedef enum logic [1:0] {
    frequency_source_mode = 2'b00,
    gradient_source_mode  = 2'b01,
    receiver_unit_mode    = 2'b10
  } rx_mode_t;

  // gradient_word_type / receiver-unit type field codes
  typedef enum logic [1:0] {
    kind_illegal = 2'b00,
    kind_data    = 2'b01,
    kind_commit  = 2'b10,
    kind_idle    = 2'b11
  } word_kind_t;

  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LEVEL   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DATA_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DATA_HI = 8'h10;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EN_BIT   = 2;
  localparam int CTRL_CLR_BIT  = 3;
  localparam int ST_MODE_LSB   = 6;

  localparam int EVEN_PAR_POS = 47;
  localparam int SYNC_POS     = 46;
  localparam int WSEL_POS     = 45;
  localparam int STAMP_LSB    = 48;

  localparam rx_mode_t MODE_RST = frequency_source_mode;
  localparam logic     EN_RST   = 1'b0;
endpackage

// >>> rx_fifo.sv
// receive fifo holding stamped 64-bit entries
`timescale 1ns/1ps
module rx_fifo import lwc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // access
  fifo_if.mem      fio
);
  typedef struct packed {
    logic [FIFO_AW:0] wp;
    logic [FIFO_AW:0] rp;
  } ptr_t;

  ptr_t q, n;
  logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
  logic do_push;
  logic do_pop;

  assign fio.level = q.wp - q.rp;
  assign fio.empty = (q.wp == q.rp);
  assign fio.full = (q.wp[FIFO_AW] != q.rp[FIFO_AW])
                 && (q.wp[FIFO_AW-1:0] == q.rp[FIFO_AW-1:0]);
  assign fio.rdata = mem[q.rp[FIFO_AW-1:0]];
  assign do_push = fio.push && !fio.full;
  assign do_pop = fio.pop && !fio.empty;

  always_comb begin
    n = q;
    if (fio.clr) begin
      n = '0;
    end else begin
      if (do_push) n.wp = q.wp + 1'b1;
      if (do_pop) n.rp = q.rp + 1'b1;
    end
  end

  // storage kept apart from the state struct, it is too large to reset
  always_ff @(posedge ref_clk) begin
    if (do_push) mem[q.wp[FIFO_AW-1:0]] <= fio.wdata;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
